// [spi_cfg_pkg.sv]
//
// Purpose: Shared constants and types for the serial configuration port.
// Assumes: 20 MHz system clock on both ends.
// Notes:   Offsets are register addresses inside the 13-bit space.
//
`default_nettype none

package spi_cfg_pkg;

  // Clock and serial timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int SCLK_HALF_NS  = 600;
  localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STALL_NS      = 1200;
  localparam int STALL_CYC     = (STALL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [4:0] HALF_LAST  = 5'(SCLK_HALF_CYC - 1);
  localparam logic [4:0] STALL_LAST = 5'(STALL_CYC - 1);

  // Frame layout
  localparam int ADDR_W  = 13;
  localparam int RW_BIT  = 15;
  localparam int WLEN_HI = 14;
  localparam int WLEN_LO = 13;
  localparam logic [3:0] INSTR_LAST  = 4'hf;
  localparam logic [3:0] BYTE_LAST   = 4'h7;
  localparam logic [1:0] WLEN_STREAM = 2'h3;

  // Sample path
  localparam int SAMPLE_W     = 14;
  localparam int PIPE_LATENCY = 10;

  // Register map
  localparam logic [ADDR_W-1:0] ADDR_PORT_CFG = 13'h0000;
  localparam logic [ADDR_W-1:0] ADDR_OUT_MODE = 13'h0014;
  localparam logic [ADDR_W-1:0] ADDR_TRANSFER = 13'h00ff;
  localparam logic [7:0] PORT_CFG_RST   = 8'h18;
  localparam logic [7:0] LSB_FIRST_MASK = 8'h42;
  localparam logic [7:0] OUT_MODE_RST   = 8'h01;
  localparam int LSB_FIRST_HI    = 6;
  localparam int LSB_FIRST_LO    = 1;
  localparam int OUT_DISABLE_BIT = 4;
  localparam int TRANSFER_BIT    = 0;
  localparam logic [1:0] FMT_TWOS = 2'h1;

  // Pin synchroniser reset: select idles high
  localparam logic [2:0] PIN_RST = 3'h2;

  typedef enum logic [2:0]
  {
    DEV_IDLE  = 3'b001,
    DEV_INSTR = 3'b010,
    DEV_DATA  = 3'b100
  } dev_state_t;

  typedef enum logic [3:0]
  {
    H_IDLE  = 4'b0001,
    H_LOW   = 4'b0010,
    H_HIGH  = 4'b0100,
    H_STALL = 4'b1000
  } host_state_t;

  // Bit reversal for the least-significant-first order
  function automatic logic [7:0] bit_rev8(input logic [7:0] v);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++)
    begin
      r[i] = v[7 - i];
    end
    return r;
  endfunction

endpackage

`default_nettype wire

// [spi_cfg_if.sv]
//
// Purpose: Three-wire serial link between host and converter port.
// Assumes: Shared data line is pulled high when nobody drives it.
// Notes:   Wire level is resolved here from the two enables.
//
`timescale 1ns/1ns
`default_nettype none

interface spi_cfg_if;
  logic sclk;
  logic port_select_n;
  logic host_sdio_out;
  logic host_sdio_oe;
  logic dev_sdio_out;
  logic dev_sdio_oe;
  logic sdio;

  // Line resolution, host wins only during a contention fault
  assign sdio = host_sdio_oe ? host_sdio_out : (dev_sdio_oe ? dev_sdio_out : 1'b1);

  modport dev
  (
    input  sclk,
    input  port_select_n,
    input  sdio,
    output dev_sdio_out,
    output dev_sdio_oe
  );

  modport host
  (
    output sclk,
    output port_select_n,
    output host_sdio_out,
    output host_sdio_oe,
    input  sdio
  );
endinterface

`default_nettype wire

// [spi_cfg_device.sv]
//
// Purpose: Converter end: serial configuration port plus output sample path.
// Assumes: Serial pins are asynchronous; samples arrive on clk as offset binary.
// Notes:   One output word every two clk cycles; capture clock rises mid-word.
//
// Functional notes
// - Sample appears ten sample clocks later
// - Output word updates on each sample edge
// - Capture clock driven beside data bus
// - Offset binary: zero, midscale, all ones
// - Twos complement default, signed extremes
// - Select fall then clock rise starts frame
// - Serial activity ignored while select high
// - Select held low keeps streaming bytes
// - Select high between counted bytes only stalls
// - Select high: pins released, secondary on
// - Frame opens with sixteen instruction bits
// - Data in whole bytes, count from instruction
// - Leading instruction bit selects read/write
// - Data pin turns to output on readback
// - Most significant first unless configured otherwise
// - Serial clock and select are inputs only
// - Data pin driven only during readback
// - Host keeps port idle during conversion
// - Shadow writes apply on transfer, self-clear
// - Output disable bit releases data outputs
//
`timescale 1ns/1ns
`default_nettype none

module spi_cfg_device
(
  input  wire logic                            clk,
  input  wire logic                            nrst,
  spi_cfg_if.dev                               bus,
  input  wire logic [spi_cfg_pkg::SAMPLE_W-1:0] sample_code,
  output var  logic [spi_cfg_pkg::SAMPLE_W-1:0] sample_data,
  output var  logic                            sample_data_oe,
  output var  logic                            output_capture_clock,
  output var  logic                            secondary_fn_en
);
  import spi_cfg_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: bit 2 serial clock, bit 1 select, bit 0 data

  logic [2:0]          pin_s1;
  logic [2:0]          pin_s2;
  logic [2:0]          pin_s3;
  logic [2:0]          pin_f;
  logic [2:0]          next_pin_f;
  logic                sclk_rise;
  logic                sclk_fall;
  logic                cs_fall;
  logic                cs_rise;
  logic                cs_low;
  logic                sdio_bit;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pin_s1 <= PIN_RST;
      pin_s2 <= PIN_RST;
      pin_s3 <= PIN_RST;
      pin_f  <= PIN_RST;
    end
    else
    begin
      pin_s1 <= {bus.sclk, bus.port_select_n, bus.sdio};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      pin_f  <= next_pin_f;
    end
  end

  // A change is accepted only once stages two and three agree
  assign next_pin_f = (~(pin_s2 ^ pin_s3) & pin_s3) | ((pin_s2 ^ pin_s3) & pin_f);
  assign cs_low     = ~next_pin_f[1];
  assign cs_fall    = ~next_pin_f[1] & pin_f[1];
  assign cs_rise    = next_pin_f[1] & ~pin_f[1];
  assign sclk_rise  = next_pin_f[2] & ~pin_f[2] & cs_low;
  assign sclk_fall  = ~next_pin_f[2] & pin_f[2] & cs_low;
  assign sdio_bit   = next_pin_f[0];

  ////////////////////////////////////////////////////////////////////////
  // Frame decode

  dev_state_t          state;
  logic [3:0]          bit_cnt;
  logic [14:0]         instr;
  logic                rw;
  logic                stream;
  logic [1:0]          bytes_left;
  logic [ADDR_W-1:0]   addr;
  logic [6:0]          wr_shift;
  logic [15:0]         next_instr;
  logic [7:0]          wr_msb;
  logic [7:0]          wr_byte;
  logic                instr_done;
  logic                byte_done;
  logic                last_byte;
  logic                stall_ok;
  logic                lsb_first;

  assign next_instr = {instr, sdio_bit};
  assign wr_msb     = {wr_shift, sdio_bit};
  assign wr_byte    = lsb_first ? bit_rev8(wr_msb) : wr_msb;
  assign instr_done = (state == DEV_INSTR) && (bit_cnt == INSTR_LAST) && sclk_rise;
  assign byte_done  = (state == DEV_DATA) && (bit_cnt == BYTE_LAST) && sclk_rise;
  assign last_byte  = ~stream && (bytes_left == 2'h0);
  // select may rise only at a byte boundary to stall
  assign stall_ok   = (state == DEV_DATA) && (bit_cnt == 4'h0) && ~stream;

  // State and counters; a stalled frame resumes on the next select fall
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state      <= DEV_IDLE;
      bit_cnt    <= 4'h0;
      rw         <= 1'b0;
      stream     <= 1'b0;
      bytes_left <= 2'h0;
      addr       <= '0;
    end
    // select fall opens a new frame outside the data phase
    else if (cs_fall && state != DEV_DATA)
    begin
      state   <= DEV_INSTR;
      bit_cnt <= 4'h0;
    end
    // streaming ends only when select rises
    else if (cs_rise && !stall_ok)
    begin
      state <= DEV_IDLE;
    end
    // leading bit picks read or write
    else if (instr_done)
    begin
      state      <= DEV_DATA;
      bit_cnt    <= 4'h0;
      rw         <= next_instr[RW_BIT];
      stream     <= next_instr[WLEN_HI:WLEN_LO] == WLEN_STREAM;
      bytes_left <= next_instr[WLEN_HI:WLEN_LO];
      addr       <= next_instr[ADDR_W-1:0];
    end
    else if (byte_done)
    begin
      bit_cnt    <= 4'h0;
      addr       <= addr + 1'b1;
      bytes_left <= bytes_left - 1'b1;
      if (last_byte)
      begin
        state <= DEV_IDLE;
      end
    end
    else if (sclk_rise && state != DEV_IDLE)
    begin
      bit_cnt <= bit_cnt + 1'b1;
    end
  end

  // Shift registers for instruction and write data
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      instr    <= '0;
      wr_shift <= '0;
    end
    else if (sclk_rise)
    begin
      instr    <= next_instr[14:0];
      wr_shift <= wr_msb[6:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers: port configuration live, output mode shadowed

  logic [7:0]          out_mode_sh;
  logic [7:0]          out_mode_act;
  logic [7:0]          port_cfg_val;
  logic [7:0]          reg_val;
  logic                do_write;

  assign do_write     = byte_done && !rw;
  assign port_cfg_val = lsb_first ? (PORT_CFG_RST | LSB_FIRST_MASK) : PORT_CFG_RST;
  // Transfer bit clears itself, so it always reads back as zero
  assign reg_val      = (addr == ADDR_PORT_CFG) ? port_cfg_val :
                        (addr == ADDR_OUT_MODE) ? out_mode_sh : 8'h00;

  // Mirrored order bits make this write safe in either order
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      lsb_first    <= 1'b0;
      out_mode_sh  <= OUT_MODE_RST;
      out_mode_act <= OUT_MODE_RST;
    end
    else if (do_write)
    begin
      if (addr == ADDR_PORT_CFG)
      begin
        lsb_first <= wr_byte[LSB_FIRST_HI] | wr_byte[LSB_FIRST_LO];
      end
      if (addr == ADDR_OUT_MODE)
      begin
        out_mode_sh <= wr_byte;
      end
      if (addr == ADDR_TRANSFER && wr_byte[TRANSFER_BIT])
      begin
        out_mode_act <= out_mode_sh;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Readback drive: bits change on serial clock falls

  logic [7:0]          rd_byte;
  logic [7:0]          rd_shift;
  logic                sdio_out;
  logic                sdio_oe;

  assign rd_byte = lsb_first ? bit_rev8(reg_val) : reg_val;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sdio_out <= 1'b0;
      sdio_oe  <= 1'b0;
      rd_shift <= 8'h00;
    end
    else if (cs_rise || (byte_done && last_byte))
    begin
      sdio_oe <= 1'b0;
    end
    else if (sclk_fall && state == DEV_DATA && rw)
    begin
      sdio_oe  <= 1'b1;
      sdio_out <= (bit_cnt == 4'h0) ? rd_byte[7] : rd_shift[7];
      rd_shift <= (bit_cnt == 4'h0) ? {rd_byte[6:0], 1'b0} : {rd_shift[6:0], 1'b0};
    end
  end

  assign bus.dev_sdio_out = sdio_out;
  assign bus.dev_sdio_oe  = sdio_oe;

  ////////////////////////////////////////////////////////////////////////
  // Sample path: capture clock high marks the update edge

  logic [SAMPLE_W-1:0] pipe [PIPE_LATENCY];
  logic [SAMPLE_W-1:0] coded;
  logic                twos;

  // twos complement flips the top bit
  assign twos  = out_mode_act[1:0] == FMT_TWOS;
  // offset binary passes the code as is
  assign coded = twos ? {~pipe[PIPE_LATENCY-1][SAMPLE_W-1], pipe[PIPE_LATENCY-1][SAMPLE_W-2:0]}
                      : pipe[PIPE_LATENCY-1];

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      for (int i = 0; i < PIPE_LATENCY; i++)
      begin
        pipe[i] <= '0;
      end
    end
    else if (output_capture_clock)
    begin
      pipe[0] <= sample_code;
      for (int i = 1; i < PIPE_LATENCY; i++)
      begin
        pipe[i] <= pipe[i-1];
      end
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sample_data          <= '0;
      sample_data_oe       <= 1'b0;
      output_capture_clock <= 1'b0;
      secondary_fn_en      <= 1'b1;
    end
    else
    begin
      if (output_capture_clock)
      begin
        sample_data <= coded;
      end
      output_capture_clock <= ~output_capture_clock;
      sample_data_oe       <= ~out_mode_act[OUT_DISABLE_BIT];
      // select high turns on secondary use
      secondary_fn_en      <= pin_f[1];
    end
  end

endmodule

`default_nettype wire

// [spi_cfg_host.sv]
//
// Purpose: Host end: generates frames on the three-wire configuration link.
// Assumes: User holds command fields while busy; next write byte follows tx_taken.
// Notes:   Serial clock is divided down from clk; stalls only at byte boundaries.
//
`timescale 1ns/1ns
`default_nettype none

module spi_cfg_host
(
  input  wire logic                            clk,
  input  wire logic                            nrst,
  spi_cfg_if.host                              bus,
  input  wire logic                            start,
  input  wire logic                            cmd_read,
  input  wire logic [1:0]                      cmd_wlen,
  input  wire logic [spi_cfg_pkg::ADDR_W-1:0]  cmd_addr,
  input  wire logic                            lsb_first,
  input  wire logic [7:0]                      tx_byte,
  input  wire logic                            stall_req,
  input  wire logic                            stream_stop,
  output var  logic                            busy,
  output var  logic                            tx_taken,
  output var  logic                            byte_done,
  output var  logic [7:0]                      rx_byte
);
  import spi_cfg_pkg::*;

  host_state_t state;
  logic [4:0]  tmr;
  logic [3:0]  bit_cnt;
  logic        in_instr;
  logic        rd;
  logic        stream;
  logic [1:0]  bytes_left;
  logic [15:0] shift;
  logic [7:0]  rx;
  logic        sclk;
  logic        csn;
  logic        sdio_out;
  logic        sdio_oe;
  logic        sd_s1;
  logic        sd_s2;
  logic        sd_s3;
  logic        sd_f;
  logic [7:0]  tx_ord;
  logic        half_end;
  logic        unit_end;
  logic        last;

  ////////////////////////////////////////////////////////////////////////
  // Readback input: three stages, accepted when two and three agree

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sd_s1 <= 1'b1;
      sd_s2 <= 1'b1;
      sd_s3 <= 1'b1;
      sd_f  <= 1'b1;
    end
    else
    begin
      sd_s1 <= bus.sdio;
      sd_s2 <= sd_s1;
      sd_s3 <= sd_s2;
      sd_f  <= (sd_s2 == sd_s3) ? sd_s3 : sd_f;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Frame sequencer

  assign tx_ord   = lsb_first ? bit_rev8(tx_byte) : tx_byte;
  assign half_end = tmr == HALF_LAST;
  assign unit_end = in_instr ? (bit_cnt == INSTR_LAST) : (bit_cnt == BYTE_LAST);
  assign last     = stream ? stream_stop : (bytes_left == 2'h0);

  // Data changes on falls, device samples on rises
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state <= H_IDLE;
      tmr <= 5'h00;
      bit_cnt <= 4'h0;
      in_instr <= 1'b0;
      rd <= 1'b0;
      stream <= 1'b0;
      bytes_left <= 2'h0;
      shift <= 16'h0000;
      rx <= 8'h00;
      rx_byte <= 8'h00;
      sclk <= 1'b0;
      csn <= 1'b1;
      sdio_out <= 1'b0;
      sdio_oe <= 1'b0;
      busy <= 1'b0;
      tx_taken <= 1'b0;
      byte_done <= 1'b0;
    end
    else
    begin
      tx_taken  <= 1'b0;
      byte_done <= 1'b0;
      tmr       <= tmr + 1'b1;
      unique case (state)
        H_IDLE:
        begin
          tmr <= 5'h00;
          if (start)
          begin
            state      <= H_LOW;
            csn        <= 1'b0;
            busy       <= 1'b1;
            in_instr   <= 1'b1;
            bit_cnt    <= 4'h0;
            rd         <= cmd_read;
            stream     <= cmd_wlen == WLEN_STREAM;
            bytes_left <= cmd_wlen;
            shift      <= {cmd_read, cmd_wlen, cmd_addr};
            sdio_out   <= cmd_read;
            sdio_oe    <= 1'b1;
          end
        end
        H_LOW:
        begin
          if (half_end)
          begin
            state <= H_HIGH;
            tmr   <= 5'h00;
            sclk  <= 1'b1;
            shift <= {shift[14:0], 1'b0};
            rx    <= {rx[6:0], sd_f};
          end
        end
        H_HIGH:
        begin
          if (half_end)
          begin
            tmr  <= 5'h00;
            sclk <= 1'b0;
            state <= H_LOW;
            if (!unit_end)
            begin
              bit_cnt  <= bit_cnt + 1'b1;
              sdio_out <= shift[15];
            end
            else
            begin
              bit_cnt  <= 4'h0;
              in_instr <= 1'b0;
              if (!in_instr)
              begin
                byte_done  <= 1'b1;
                rx_byte    <= lsb_first ? bit_rev8(rx) : rx;
                bytes_left <= bytes_left - 1'b1;
              end
              if (!in_instr && last)
              begin
                state   <= H_IDLE;
                csn     <= 1'b1;
                sdio_oe <= 1'b0;
                busy    <= 1'b0;
              end
              else
              begin
                tx_taken <= 1'b1;
                shift    <= {tx_ord, 8'h00};
                sdio_out <= tx_ord[7];
                sdio_oe  <= ~rd;
                if (!in_instr && stall_req)
                begin
                  state <= H_STALL;
                  csn   <= 1'b1;
                end
              end
            end
          end
        end
        H_STALL:
        begin
          if (tmr == STALL_LAST)
          begin
            state <= H_LOW;
            tmr   <= 5'h00;
            csn   <= 1'b0;
          end
        end
      endcase
    end
  end

  assign bus.sclk          = sclk;
  assign bus.port_select_n = csn;
  assign bus.host_sdio_out = sdio_out;
  assign bus.host_sdio_oe  = sdio_oe;

endmodule

`default_nettype wire

// [spi_cfg_checker.sv]
// Purpose: Wire checks on the link between host and device ends.
// Assumes: Both ends run on clk and share nrst.
// Notes:   Sees only the interface signals.
`timescale 1ns/1ns
`default_nettype none

module spi_cfg_checker
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic sclk,
  input wire logic port_select_n,
  input wire logic host_sdio_out,
  input wire logic host_sdio_oe,
  input wire logic dev_sdio_out,
  input wire logic dev_sdio_oe,
  input wire logic sdio
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  ////////////////////////////////////////////////////////////////
  // single line driver
  chk_no_contention: assert property (!(host_sdio_oe && dev_sdio_oe))
    else $error("both ends drive the data line");
  // release on deselect; filter lag allowed
  chk_sel_drops_dev: assert property ($rose(port_select_n) |-> ##[0:6] !dev_sdio_oe)
    else $error("device kept data line after deselect");
  chk_sclk_half: assert property ($rose(sclk) |-> sclk[*8] ##1 sclk[*4] ##1 !sclk)
    else $error("serial clock high half not twelve cycles");
  chk_sel_then_clk: assert property ($fell(port_select_n) |-> !sclk[*8])
    else $error("serial clock rose too soon after select");
  chk_clk_idle: assert property (port_select_n |-> !sclk)
    else $error("serial clock active while deselected");
  // host bit held while clock high
  chk_host_hold: assert property (sclk && host_sdio_oe |-> $stable(host_sdio_out))
    else $error("host bit changed while clock high");
  // device bit held while clock high
  chk_dev_hold: assert property (sclk && dev_sdio_oe |-> $stable(sdio))
    else $error("device bit changed while clock high");
  chk_turnaround: assert property ($fell(host_sdio_oe) && !port_select_n |-> ##[1:12] dev_sdio_oe)
    else $error("device did not take line on readback");
  // device enables only in low half
  chk_dev_turn_on: assert property ($rose(dev_sdio_oe) |-> !port_select_n && !sclk)
    else $error("device enabled outside readback slot");
endmodule

`default_nettype wire

// [converter_serial_config_port_bench.sv]
// Purpose: Bench joining host and device ends over the link.
// Assumes: One clk for both ends; inputs change at falling edge.
// Notes:   Wire bits are captured at serial clock rises.
`timescale 1ns/1ns
`default_nettype none

module converter_serial_config_port_bench;
  import spi_cfg_pkg::*;
  logic        clk, nrst, start, cmd_read, lsb_first, stall_req, stream_stop;
  logic        busy, tx_taken, byte_done, oc, sdata_oe, sec_en, sec_seen = 1'b0;
  logic [1:0]  cmd_wlen;
  logic [12:0] cmd_addr;
  logic [7:0]  tx_byte, rx_byte, txq[4], rxq[4];
  logic [13:0] sample_code, sample_data;
  logic [23:0] wire_bits;
  int          err_total = 0;
  int          checks_done = 0;

  ////////////////////////////////////////////////////////////////
  spi_cfg_if spi_cfg_if_inst ();
  spi_cfg_device spi_cfg_device_inst (.clk(clk), .nrst(nrst), .bus(spi_cfg_if_inst), .sample_code(sample_code),
    .sample_data(sample_data), .sample_data_oe(sdata_oe), .output_capture_clock(oc), .secondary_fn_en(sec_en));
  spi_cfg_host spi_cfg_host_inst (.clk(clk), .nrst(nrst), .bus(spi_cfg_if_inst), .start(start),
    .cmd_read(cmd_read), .cmd_wlen(cmd_wlen), .cmd_addr(cmd_addr), .lsb_first(lsb_first), .tx_byte(tx_byte),
    .stall_req(stall_req), .stream_stop(stream_stop), .busy(busy), .tx_taken(tx_taken),
    .byte_done(byte_done), .rx_byte(rx_byte));
  spi_cfg_checker spi_cfg_checker_inst (.clk(clk), .nrst(nrst), .sclk(spi_cfg_if_inst.sclk),
    .port_select_n(spi_cfg_if_inst.port_select_n), .host_sdio_out(spi_cfg_if_inst.host_sdio_out),
    .host_sdio_oe(spi_cfg_if_inst.host_sdio_oe), .dev_sdio_out(spi_cfg_if_inst.dev_sdio_out),
    .dev_sdio_oe(spi_cfg_if_inst.dev_sdio_oe), .sdio(spi_cfg_if_inst.sdio));

  // Clock generator
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Wire monitor; secondary enable must be off during frames
  always @(posedge spi_cfg_if_inst.sclk)
  begin
    if (!spi_cfg_if_inst.port_select_n)
      wire_bits <= {wire_bits[22:0], spi_cfg_if_inst.sdio};
    sec_seen <= sec_seen | sec_en;
  end

  ////////////////////////////////////////////////////////////////
  task automatic summarize;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic cmp(string nm, logic [23:0] exp, logic [23:0] got);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value %s exp %h got %h", nm, exp, got);
    end
  endtask

  // One frame; next byte loaded on tx_taken, stop before the last
  task automatic xfer(logic rd, logic [1:0] wl, logic [12:0] a, int n);
    int k;
    int j;
    int t;
    k = 0;
    j = 0;
    // Select must idle high a few clk, or the device filter hides the gap
    repeat (4) @(negedge clk);
    cmd_read = rd;
    cmd_wlen = wl;
    cmd_addr = a;
    tx_byte = txq[0];
    stream_stop = (n == 1);
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    for (t = 0; t < 4000 && busy !== 1'b0; t++)
    begin
      if (tx_taken === 1'b1 && k < 3)
      begin
        k++;
        tx_byte = txq[k];
      end
      if (byte_done === 1'b1 && j < 4)
      begin
        rxq[j] = rx_byte;
        j++;
        stream_stop = (j >= n - 1);
      end
      @(negedge clk);
    end
    // Last byte_done pulse lands on the edge that drops busy
    if (byte_done === 1'b1 && j < 4)
      rxq[j] = rx_byte;
    if (t == 4000)
    begin
      err_total++;
      summarize();
    end
  endtask

  task automatic wr(logic [12:0] a, logic [7:0] d);
    txq[0] = d;
    xfer(1'b0, 2'h0, a, 1);
  endtask

  task automatic rdchk(string nm, logic [12:0] a, logic [7:0] exp);
    xfer(1'b1, 2'h0, a, 1);
    cmp(nm, exp, rxq[0]);
  endtask

  // Each capture takes a new code; word due ten captures later
  task automatic samples(logic ofs);
    logic [13:0] vals[7] = '{14'h0000, 14'h2000, 14'h3fff, 14'h1234, 14'h2fed, 14'h0aaa, 14'h1555};
    logic [13:0] h[$];
    logic [13:0] e;
    logic        p;
    p = oc;
    for (int c = 0; c < 80; c++)
    begin
      @(negedge clk);
      cmp("capture_clk", !p, oc);
      p = oc;
      if (oc === 1'b1)
      begin
        sample_code = vals[h.size() % 7];
        h.push_back(sample_code);
      end
      else if (h.size() >= 11)
      begin
        e = h[h.size() - 11];
        cmp("sample", ofs ? e : e ^ 14'h2000, sample_data);
      end
    end
  endtask

  ////////////////////////////////////////////////////////////////
  // Reset values of port and coding
  task automatic check_defaults;
    cmp("sec_idle", 1, sec_en);
    rdchk("port_cfg", 13'h0000, 8'h18);
    rdchk("out_mode", 13'h0014, 8'h01);
    samples(1'b0);
  endtask

  // Shadowed output mode only applies after transfer
  task automatic check_shadow;
    wire_bits = 24'h00_0000;
    wr(13'h0014, 8'h00);
    cmp("wire_msb", 24'h00_1400, wire_bits);
    samples(1'b0);
    rdchk("shadow", 13'h0014, 8'h00);
    wr(13'h00ff, 8'h01);
    rdchk("xfer_bit", 13'h00ff, 8'h00);
    samples(1'b1);
  endtask

  // Least-significant-first data and output disable
  task automatic check_lsb_order;
    wr(13'h0000, 8'h42);
    lsb_first = 1'b1;
    rdchk("lsb_cfg", 13'h0000, 8'h5a);
    wire_bits = 24'h00_0000;
    wr(13'h0014, 8'h10);
    cmp("wire_lsb", 24'h00_1408, wire_bits);
    wr(13'h00ff, 8'h01);
    repeat (2) @(negedge clk);
    cmp("out_off", 0, sdata_oe);
    wr(13'h0000, 8'h18);
    lsb_first = 1'b0;
    rdchk("msb_cfg", 13'h0000, 8'h18);
  endtask

  // Two-byte write with a stall between the bytes
  task automatic check_stall;
    txq[0] = 8'h77;
    txq[1] = 8'h01;
    stall_req = 1'b1;
    xfer(1'b0, 2'h1, 13'h0013, 2);
    stall_req = 1'b0;
    rdchk("stalled", 13'h0014, 8'h01);
    wr(13'h00ff, 8'h01);
    repeat (2) @(negedge clk);
    cmp("out_on", 1, sdata_oe);
  endtask

  // Counted and streamed multi-byte readback
  task automatic check_multi;
    xfer(1'b1, 2'h2, 13'h0012, 3);
    cmp("three_0", 8'h00, rxq[0]);
    cmp("three_2", 8'h01, rxq[2]);
    xfer(1'b1, 2'h3, 13'h0012, 4);
    cmp("stream_2", 8'h01, rxq[2]);
    cmp("stream_3", 8'h00, rxq[3]);
    cmp("sec_frame", 0, sec_seen);
    samples(1'b0);
  endtask

  ////////////////////////////////////////////////////////////////
  initial
  begin
    nrst = 1'b0;
    start = 1'b0;
    cmd_read = 1'b0;
    cmd_wlen = 2'h0;
    cmd_addr = 13'h0000;
    lsb_first = 1'b0;
    tx_byte = 8'h00;
    stall_req = 1'b0;
    stream_stop = 1'b0;
    sample_code = 14'h0000;
    repeat (3) @(negedge clk);
    nrst = 1'b1;
    repeat (5) @(negedge clk);
    check_defaults();
    check_shadow();
    check_lsb_order();
    check_stall();
    check_multi();
    summarize();
  end
endmodule

`default_nettype wire
